// [timer_pkg.sv]
// constants shared by the prescaled down-counter timer
package timer_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte addresses on the apb bus
    localparam int unsigned ADDR_W            = 12;
    localparam logic [11:0] ADDR_COUNT        = 12'h000;
    localparam logic [11:0] ADDR_CONTROL      = 12'h004;
    localparam logic [11:0] ADDR_POWER        = 12'h008;

    ////////////////////////////////////////////////////////////////////////////////
    // control register field positions
    localparam int unsigned CTRL_W            = 7;
    localparam int unsigned CTRL_SEL_LSB      = 0;
    localparam int unsigned CTRL_SEL_MSB      = 3;
    localparam int unsigned CTRL_COUNT_BIT    = 4;
    localparam int unsigned CTRL_RELOAD_BIT   = 5;
    localparam int unsigned CTRL_PWR_BIT      = 6;

    // power control register field position
    localparam int unsigned POWER_TIMER_BIT   = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // widths and values after reset
    localparam int unsigned CNT_W             = 16;
    localparam logic [15:0] COUNT_RST         = 16'h0000;
    localparam logic [15:0] PERIOD_RST        = 16'h0000;
    localparam logic [6:0]  CTRL_RST          = 7'h00;
    localparam logic [0:0]  POWER_RST         = 1'h0;
    localparam logic [15:0] DIVCOUNT_RST      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave answer: cycles in the access phase before pready is high
    localparam int unsigned APB_WAIT_CYCLES   = 1;

endpackage

// [timer_prescaler.sv]
// power-of-two prescaler that makes the counting tick
`timescale 1ns/1ps
`default_nettype none

module timer_prescaler
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control
    input  wire logic       run,
    input  wire logic [3:0] divider_select,
    // tick out
    output logic            tick
);

    logic [15:0] div_ff;
    logic [15:0] nxt_div;
    logic [4:0]  shift_amt;
    logic [16:0] mask_wide;
    logic [15:0] mask;

    ////////////////////////////////////////////////////////////////////////////////
    // divide by two to the power of (select + 1): low select+1 bits all ones
    assign shift_amt = {1'b0, divider_select} + 5'h01;                    // RULE_07
    assign mask_wide = (17'h00001 << shift_amt) - 17'h00001;              // RULE_07
    assign mask      = mask_wide[15:0];
    assign tick      = run && ((div_ff & mask) == mask);                  // RULE_07
    assign nxt_div   = run ? div_ff + 16'h0001 : div_ff;                  // RULE_03

    // free divider, frozen while the timer is stopped or powered down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= DIVCOUNT_RST;
        end else begin
            div_ff <= nxt_div;
        end
    end

endmodule

`default_nettype wire

// [prescaled_down_counter_timer.sv]
// apb-attached 16-bit prescaled down-counter timer
//
// Overview of operation
// RULE_01: reading count returns the counter; writing loads counter and period together.
// RULE_02: count register is reachable only when local and global power-off are clear.
// RULE_03: with count-enable clear, the counter holds its value.
// RULE_04: with count-enable set, the counter decrements once per prescaled tick.
// RULE_05: without auto-reload, counting stops at zero and stays there.
// RULE_06: with auto-reload, zero reloads the counter from period and counting continues.
// RULE_07: divider select n makes the tick the clock divided by two to n+1.
// RULE_08: while powered down, counter and period keep their contents.
// RULE_09: reset clears the count; control comes up stopped and powered up.
`timescale 1ns/1ps
`default_nettype none

module prescaled_down_counter_timer
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer event
    output logic             expired
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic [15:0] period_ff;
    logic [15:0] nxt_period;
    logic [6:0]  ctrl_ff;
    logic [6:0]  nxt_ctrl;
    logic [0:0]  power_ff;
    logic [0:0]  nxt_power;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic        expired_ff;
    logic        nxt_expired;

    logic        hit_count;
    logic        hit_control;
    logic        hit_power;
    logic        unmapped;
    logic        access;
    logic        first_access;
    logic        done;
    logic        bad_access;
    logic        wr_commit;
    logic        wr_count;
    logic        wr_control;
    logic        wr_power;
    logic        powered;
    logic        count_en;
    logic        reload_en;
    logic [3:0]  clock_divider_select;
    logic        local_power_off_bit;
    logic        run;
    logic        tick;
    logic        at_zero;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode and apb phase tracking
    assign hit_count    = (paddr == ADDR_COUNT);
    assign hit_control  = (paddr == ADDR_CONTROL);
    assign hit_power    = (paddr == ADDR_POWER);
    assign unmapped     = !(hit_count || hit_control || hit_power);
    assign access       = psel && penable;
    assign first_access = access && !pready_ff;
    assign done         = access && pready_ff;

    // count access while powered down is refused like an unmapped address
    assign bad_access   = unmapped || (hit_count && !powered);               // RULE_02
    assign wr_commit    = done && pwrite && !bad_access;
    assign wr_count     = wr_commit && hit_count;                            // RULE_02
    assign wr_control   = wr_commit && hit_control;
    assign wr_power     = wr_commit && hit_power;

    ////////////////////////////////////////////////////////////////////////////////
    // control fields and run state
    assign clock_divider_select = ctrl_ff[CTRL_SEL_MSB:CTRL_SEL_LSB];
    assign count_en             = ctrl_ff[CTRL_COUNT_BIT];
    assign reload_en            = ctrl_ff[CTRL_RELOAD_BIT];
    assign local_power_off_bit  = ctrl_ff[CTRL_PWR_BIT];
    assign powered              = !local_power_off_bit && !power_ff[POWER_TIMER_BIT];  // RULE_02
    assign run                  = powered && count_en;                       // RULE_03
    assign at_zero              = (count_ff == 16'h0000);

    ////////////////////////////////////////////////////////////////////////////////
    // read data mux; reserved control bits read as zero
    assign rd_mux = hit_count   ? {16'h0000, (powered ? count_ff : 16'h0000)} :  // RULE_01
                    hit_control ? {25'h0000000, ctrl_ff} :
                    hit_power   ? {31'h00000000, power_ff} :
                                  32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // apb answer: one wait cycle, then pready with data or error
    assign nxt_pready  = first_access;
    assign nxt_pslverr = first_access && bad_access;                         // RULE_02
    assign nxt_prdata  = (first_access && !pwrite && !bad_access) ? rd_mux :
                         (done ? 32'h00000000 : prdata_ff);

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler
    timer_prescaler u_prescaler (
        .pclk           (pclk),
        .presetn        (presetn),
        .run            (run),
        .divider_select (clock_divider_select),
        .tick           (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // down counter next value; a software load beats the tick in the same cycle
    always_comb begin
        nxt_count   = count_ff;
        nxt_period  = period_ff;
        nxt_expired = 1'b0;
        if (wr_count) begin
            nxt_count  = pwdata[15:0];                                       // RULE_01
            nxt_period = pwdata[15:0];                                       // RULE_01
        end else if (run && tick) begin
            if (!at_zero) begin
                nxt_count   = count_ff - 16'h0001;                           // RULE_04
                nxt_expired = (count_ff == 16'h0001);
            end else if (reload_en) begin
                nxt_count = period_ff;                                       // RULE_06
            end else begin
                nxt_count = count_ff;                                        // RULE_05
            end
        end
        // no run means no tick reaches the counter when powered down      RULE_08
    end

    // control and power registers
    assign nxt_ctrl  = wr_control ? pwdata[6:0] : ctrl_ff;
    assign nxt_power = wr_power ? pwdata[0:0] : power_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // timer state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff  <= COUNT_RST;                                          // RULE_09
            period_ff <= PERIOD_RST;
            ctrl_ff   <= CTRL_RST;                                           // RULE_09
            power_ff  <= POWER_RST;
        end else begin
            count_ff  <= nxt_count;
            period_ff <= nxt_period;
            ctrl_ff   <= nxt_ctrl;
            power_ff  <= nxt_power;
        end
    end

    // bus answer and event registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            expired_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            expired_ff <= nxt_expired;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign expired = expired_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // helper: cycles of running since the last tick, for the rate check
    logic [16:0] since_ff;
    logic        clean_ff;
    logic [16:0] div_m1;

    assign div_m1 = (17'h00001 << ({1'b0, clock_divider_select} + 5'h01)) - 17'h00001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_ff <= 17'h00000;
            clean_ff <= 1'b0;
        end else begin
            since_ff <= (tick || !run) ? 17'h00000 : since_ff + 17'h00001;
            clean_ff <= run && !wr_control && (tick || clean_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_write_loads: assert property (wr_count |=> (count_ff == $past(pwdata[15:0]))   // RULE_01
                                    && (period_ff == $past(pwdata[15:0])))
        else $error("count write did not load counter and period");

    a_read_value: assert property (first_access && !pwrite && hit_count && powered  // RULE_01
                                   |=> prdata[15:0] == $past(count_ff))
        else $error("count read returned the wrong value");

    a_locked_access: assert property (first_access && hit_count && !powered  // RULE_02
                                      |=> pready && pslverr && $stable(count_ff)
                                      && $stable(period_ff))
        else $error("count access while powered down was not refused");

    a_hold_stopped: assert property (powered && !count_en && !wr_count  // RULE_03
                                     |=> $stable(count_ff))
        else $error("counter moved while count-enable was clear");

    a_decrement: assert property (run && tick && !at_zero && !wr_count  // RULE_04
                                  |=> count_ff == $past(count_ff) - 16'h0001)
        else $error("counter did not decrement on a tick");

    a_stop_zero: assert property (run && at_zero && !reload_en && !wr_count  // RULE_05
                                  |=> at_zero)
        else $error("counter left zero without auto-reload");

    a_reload_zero: assert property (run && tick && at_zero && reload_en && !wr_count  // RULE_06
                                    |=> count_ff == $past(period_ff))
        else $error("counter was not reloaded from period at zero");

    a_tick_rate: assert property (tick && clean_ff |-> since_ff == div_m1)   // RULE_07
        else $error("prescaled tick spacing is wrong");

    a_power_hold: assert property (!powered ##1 !powered && !wr_count  // RULE_08
                                   |-> $stable(count_ff) && $stable(period_ff))
        else $error("counter or period changed while powered down");

    // bus answer checks
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");

    a_ready_idle: assert property (!psel |=> !pready)
        else $error("pready rose without a selected transfer");

    a_slverr_ready: assert property (pslverr |-> pready)  // RULE_02
        else $error("pslverr came without pready");

    a_refused_read: assert property (first_access && !pwrite && bad_access  // RULE_02
                                     |=> pslverr && prdata == 32'h00000000)
        else $error("refused read did not answer with error and zero data");

    a_prdata_clear: assert property (done |=> prdata == 32'h00000000)
        else $error("read data did not return to zero after the transfer");

    // register write checks
    a_control_write: assert property (wr_control |=> ctrl_ff == $past(pwdata[6:0]))
        else $error("control write did not land");

    a_power_write: assert property (wr_power |=> power_ff == $past(pwdata[0:0]))
        else $error("power control write did not land");

    a_period_kept: assert property (!wr_count |=> $stable(period_ff))  // RULE_06
        else $error("period changed without a count write");

    // expiry event checks
    a_expired_pulse: assert property (expired |=> !expired)
        else $error("expired stood longer than one cycle");

    a_expired_step: assert property (expired  // RULE_04
                                     |-> at_zero && $past(count_ff) == 16'h0001)
        else $error("expired without a step from one to zero");

    a_zero_quiet: assert property (at_zero && !reload_en |=> !expired)  // RULE_05
        else $error("expired fired while the counter rested at zero");

    a_apb_answer: assert property (first_access |=> pready ##1 !pready)
        else $error("apb answer timing is wrong");

    c_reload: cover property (run && tick && at_zero && reload_en);
    c_stop_zero: cover property (expired ##1 (run && at_zero && !reload_en)[*4]);
    c_write_count: cover property (wr_count ##1 run [*3]);
    c_locked: cover property (done && hit_count && !powered);
    c_refused: cover property (done && unmapped);

endmodule

`default_nettype wire

// [tb_top.sv]
// self-checking testbench for the prescaled down-counter timer
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import timer_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////////
    // design signals and bench state
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        expired;
    int          error_cnt;
    int          compares;
    integer      seed;
    logic [31:0] rd;
    logic        err;
    logic [15:0] val;
    int          gap;
    int          per;

    prescaled_down_counter_timer i_prescaled_down_counter_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .expired (expired)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // 125 mhz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // verdict, the single place where the run ends
    task automatic final_report;
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // compare data values
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // compare single-bit flags
    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // cycles between two expiry pulses: period+1 ticks of 2^(sel+1) clocks
    function automatic logic [31:0] exp_interval(input int sel, input int prd);
        return 32'((prd + 1) << (sel + 1));
    endfunction

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // count clocks until the expiry pulse, bounded
    task automatic wait_exp(input int bound, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (expired !== 1'b1 && n < bound);
        if (expired !== 1'b1) begin
            error_cnt++;
            final_report();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        error_cnt = 0;
        compares = 0;
        seed = 32'h4287c386;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // values after reset
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk_data(rd, 32'h0);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        chk_data(rd, 32'h0);
        // random loads, held while stopped; upper write bits ignored
        for (int k = 0; k < 4; k++) begin
            val = 16'($random(seed));
            apb(1'b1, ADDR_COUNT, {16'($random(seed)), val});
            repeat (12) @(posedge pclk);
            apb(1'b0, ADDR_COUNT, 32'h0);
            chk_data(rd, {16'h0, val});
            chk_flag(err, 1'b0);
        end
        // unmapped address is refused
        apb(1'b0, 12'h00c, 32'h0);
        chk_flag(err, 1'b1);
        chk_data(rd, 32'h0);
        // local power-off: count refused, contents kept
        apb(1'b1, ADDR_CONTROL, 32'h50);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        chk_data(rd, 32'h50);
        chk_flag(err, 1'b0);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk_flag(err, 1'b1);
        chk_data(rd, 32'h0);
        apb(1'b1, ADDR_COUNT, {16'h0, ~val});
        chk_flag(err, 1'b1);
        repeat (20) @(posedge pclk);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk_data(rd, {16'h0, val});
        // global power-off with count enabled
        apb(1'b1, ADDR_POWER, 32'h1);
        apb(1'b0, ADDR_POWER, 32'h0);
        chk_data(rd, 32'h1);
        apb(1'b1, ADDR_CONTROL, 32'h10);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk_flag(err, 1'b1);
        repeat (20) @(posedge pclk);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b1, ADDR_POWER, 32'h0);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk_data(rd, {16'h0, val});
        // one-shot run stops at zero and stays there
        apb(1'b1, ADDR_COUNT, 32'h3);
        apb(1'b1, ADDR_CONTROL, 32'h10);
        wait_exp(64, gap);
        repeat (40) begin
            @(posedge pclk);
            chk_flag(expired, 1'b0);
        end
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk_data(rd, 32'h0);
        // auto-reload interval for divider selects 0 to 11
        for (int s = 0; s < 12; s++) begin
            per = (s < 4) ? 1 + ({$random(seed)} % 3) : 1;
            apb(1'b1, ADDR_CONTROL, 32'h0);
            apb(1'b1, ADDR_COUNT, 32'(per));
            apb(1'b1, ADDR_CONTROL, 32'h30 | 32'(s));
            wait_exp((per + 2) << (s + 2), gap);
            wait_exp((per + 2) << (s + 2), gap);
            chk_data(32'(gap), exp_interval(s, per));
        end
        // reset in mid-run clears count and control
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CONTROL, 32'h0);
        chk_data(rd, 32'h0);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk_data(rd, 32'h0);
        final_report();
    end

endmodule
`default_nettype wire
